// ---- verilog/blc_cfg.svh ----
`ifndef BLC_CFG_SVH
`define BLC_CFG_SVH

// ==========================================
// clock and cycle conversion
`define BLC_CLK_MHZ       125
`define BLC_NS_UP(ns)     (((ns) * `BLC_CLK_MHZ + 999) / 1000)

// ==========================================
// array timings in ns
`define BLC_RCD_NS        18
`define BLC_RP_NS         18
`define BLC_RFCPB_NS      90
`define BLC_RFCAB_NS      130
`define BLC_RRD_NS        10
`define BLC_FAW_NS        50
`define BLC_XP_NS         8
`define BLC_XSR_NS        140
`define BLC_INIT_NS       10000

// ==========================================
// timer width in bits and counts in cycles
`define BLC_TW            12
`define BLC_RCD_CYC       (`BLC_NS_UP(`BLC_RCD_NS))
`define BLC_RP_CYC        (`BLC_NS_UP(`BLC_RP_NS))
`define BLC_RFCPB_CYC     (`BLC_NS_UP(`BLC_RFCPB_NS))
`define BLC_RFCAB_CYC     (`BLC_NS_UP(`BLC_RFCAB_NS))
`define BLC_RRD_CYC       (`BLC_NS_UP(`BLC_RRD_NS))
`define BLC_FAW_CYC       (`BLC_NS_UP(`BLC_FAW_NS))
`define BLC_XP_CYC        (`BLC_NS_UP(`BLC_XP_NS))
`define BLC_XSR_CYC       (`BLC_NS_UP(`BLC_XSR_NS))
`define BLC_INIT_CYC      (`BLC_NS_UP(`BLC_INIT_NS))
`define BLC_MRR_CYC       4
`define BLC_MRW_CYC       10
`define BLC_BURST_CYC     4

// ==========================================
// register map, byte addresses
`define BLC_REG_CTRL      5'h00
`define BLC_REG_STATUS    5'h04
`define BLC_REG_BANKS     5'h08
`define BLC_REG_DATA      5'h0C
`define BLC_CTRL_RST      1'h1
`define BLC_ST_ERR        0
`define BLC_ST_GATED      1
`define BLC_ST_RESETTING  2
`define BLC_ST_ALLIDLE    3
`define BLC_ST_SREF       4
`define BLC_ST_CODE_LO    8
`define BLC_BANKS         8

`endif

// ---- verilog/blc_pkg.sv ----
package blc_pkg;

    typedef enum logic [3:0] {
        BLC_NOP, BLC_ACT, BLC_RD, BLC_WR, BLC_PRE, BLC_REF_PB,
        BLC_REF_AB, BLC_MRW, BLC_MRR, BLC_SRE
    } blc_code_t;

    typedef enum logic [3:0] {
        BLC_POWER_ON, BLC_RESETTING, BLC_IDLE, BLC_ACTIVATING,
        BLC_ACTIVE, BLC_READING, BLC_WRITING, BLC_RD_AP, BLC_WR_AP,
        BLC_PRECHARGING, BLC_REFRESHING, BLC_MR_READING, BLC_MR_WRITING
    } blc_state_t;

    typedef struct packed {
        logic      valid;
        blc_code_t code;
        logic [2:0] bank;
        logic      all_bank_select;
        logic      auto_pre;
        logic      mr_reset;
    } blc_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
        logic [3:0]  write_byte_mask;
    } blc_wdata_t;

endpackage

// ---- verilog/blc_bank_command_legality.sv ----
// Contract
// - no-op leaves every bank state unchanged
// - idle other bank never restricts target
// - check with clock enable held, exit elapsed; self refresh entry checked as clock enable drops
// - idle only after precharge time elapsed
// - active after row-to-column delay, nothing pending
// - non-auto-precharge bursts enter reading or writing
// - config write runs uninterrupted, then idle
// - reads and writes allow either precharge option
// - config read allowed while activating or precharging
// - after config read, bank resumes earlier timing
// - reset from power-on or all idle enters resetting
// - auto-precharge bank does not block other banks
// - config read in resetting returns to resetting
// - masked-low bytes stored, masked-high bytes ignored
// - all-bank precharge closes every bank, ignores address
`timescale 1ns/1ns
`include "blc_cfg.svh"

module blc_bank_command_legality (
    // clock and reset
    input  wire logic               CLK,
    input  wire logic               RST,
    // command from the controller
    input  wire logic               CKE,
    input  wire blc_pkg::blc_cmd_t  CMD,
    input  wire blc_pkg::blc_wdata_t WDATA,
    // command outcome
    output logic                    CMD_ACCEPT,
    output logic                    CMD_ILLEGAL,
    output logic [7:0]              BANK_IDLE,
    output logic [31:0]             STORED_DATA,
    // avalon-mm slave
    input  wire logic [4:0]         AVS_ADDRESS,
    input  wire logic               AVS_READ,
    input  wire logic               AVS_WRITE,
    input  wire logic [31:0]        AVS_WRITEDATA,
    input  wire logic [3:0]         AVS_BYTEENABLE,
    output logic [31:0]             AVS_READDATA,
    output logic                    AVS_WAITREQUEST
);

    // ==========================================
    // helpers
    function automatic logic is_open(input blc_pkg::blc_state_t s);
        is_open = (s == blc_pkg::BLC_ACTIVE) ||
                  (s == blc_pkg::BLC_READING) ||
                  (s == blc_pkg::BLC_WRITING);
    endfunction

    function automatic logic is_dev_wide(input blc_pkg::blc_code_t c);
        is_dev_wide = (c == blc_pkg::BLC_REF_AB) ||
                      (c == blc_pkg::BLC_MRW);
    endfunction

    // ==========================================
    // state
    blc_pkg::blc_state_t      st  [`BLC_BANKS];
    blc_pkg::blc_state_t      ret [`BLC_BANKS];
    logic [`BLC_TW-1:0]       tm  [`BLC_BANKS];
    logic [`BLC_TW-1:0]       mtm [`BLC_BANKS];
    logic [`BLC_TW-1:0]       faw [4];
    logic [1:0]               faw_ptr;
    logic [`BLC_TW-1:0]       rrd;
    logic [`BLC_TW-1:0]       xt;
    logic                     cke_prev;
    logic                     sref;
    logic                     err;
    logic [3:0]               err_code;
    logic                     chk_en;
    logic [31:0]              data;
    logic                     ack;
    logic [7:0]               idle_v;
    logic [7:0]               pre_ok_v;
    logic [7:0]               pwr_v;
    logic [7:0]               rst_v;

    // ==========================================
    // command qualification
    wire cke_held   = cke_prev & CKE;
    wire cmd_live   = CMD.valid & cke_held & (xt == '0);
    wire is_nop     = CMD.code == blc_pkg::BLC_NOP;
    wire is_reset   = (CMD.code == blc_pkg::BLC_MRW) & CMD.mr_reset;
    wire all_idle   = &idle_v;
    wire all_pre_ok = &pre_ok_v;
    wire all_pwr    = &pwr_v;
    wire blc_pkg::blc_state_t tgt = st[CMD.bank];
    wire tgt_bd     = tm[CMD.bank] == '0;
    wire act_gap_ok = (rrd == '0) & (faw[faw_ptr] == '0);

    wire l_act = (tgt == blc_pkg::BLC_IDLE) & act_gap_ok;
    wire l_rd  = (tgt == blc_pkg::BLC_ACTIVE) |
                 (tgt == blc_pkg::BLC_READING) |
                 ((tgt == blc_pkg::BLC_WRITING) & tgt_bd);
    wire l_wr  = (tgt == blc_pkg::BLC_ACTIVE) |
                 (tgt == blc_pkg::BLC_WRITING) |
                 ((tgt == blc_pkg::BLC_READING) & tgt_bd);
    wire l_pre = CMD.all_bank_select ? all_pre_ok
                                     : pre_ok_v[CMD.bank];
    wire l_mrr = (tgt == blc_pkg::BLC_IDLE) |
                 (tgt == blc_pkg::BLC_ACTIVE) |
                 (tgt == blc_pkg::BLC_ACTIVATING) |
                 (tgt == blc_pkg::BLC_PRECHARGING) |
                 (tgt == blc_pkg::BLC_RESETTING);
    wire l_rst = all_pwr | all_idle;

    logic legal;
    always_comb
    begin
        case (CMD.code)
            blc_pkg::BLC_NOP:    legal = 1'b1;
            blc_pkg::BLC_ACT:    legal = l_act;
            blc_pkg::BLC_RD:     legal = l_rd;
            blc_pkg::BLC_WR:     legal = l_wr;
            blc_pkg::BLC_PRE:    legal = l_pre;
            blc_pkg::BLC_REF_PB: legal = tgt == blc_pkg::BLC_IDLE;
            blc_pkg::BLC_REF_AB: legal = all_idle;
            blc_pkg::BLC_MRW:    legal = is_reset ? l_rst : all_idle;
            blc_pkg::BLC_MRR:    legal = l_mrr;
            blc_pkg::BLC_SRE:    legal = 1'b0;
            default:             legal = 1'b0;
        endcase
    end

    // self refresh entry is taken on the edge where clock enable drops
    wire sre_acc = CMD.valid & (CMD.code == blc_pkg::BLC_SRE) &
                   cke_prev & ~CKE & all_idle & (xt == '0);
    wire acc     = cmd_live & ~is_nop & legal;
    wire bad     = (cmd_live & ~is_nop & ~legal) |
                   (CMD.valid & cke_held & ~is_nop & (xt != '0));
    wire act_acc = acc & (CMD.code == blc_pkg::BLC_ACT);

    assign CMD_ACCEPT  = acc | sre_acc;
    assign CMD_ILLEGAL = bad;
    assign BANK_IDLE   = idle_v;

    // ==========================================
    // per-bank state machines
    genvar b;
    generate
        for (b = 0; b < `BLC_BANKS; b = b + 1)
        begin : g_bank
            blc_pkg::blc_state_t next_st;
            blc_pkg::blc_state_t next_ret;
            logic [`BLC_TW-1:0]  next_tm;
            logic [`BLC_TW-1:0]  next_mtm;
            wire mine = acc & ((CMD.bank == 3'(b)) | is_dev_wide(CMD.code) |
                        ((CMD.code == blc_pkg::BLC_PRE) &
                         CMD.all_bank_select));

            assign idle_v[b]   = st[b] == blc_pkg::BLC_IDLE;
            assign pwr_v[b]    = st[b] == blc_pkg::BLC_POWER_ON;
            assign rst_v[b]    = st[b] == blc_pkg::BLC_RESETTING;
            assign pre_ok_v[b] = idle_v[b] | (is_open(st[b]) &
                                 (tm[b] == '0));

            always_comb
            begin
                next_st  = st[b];
                next_ret = ret[b];
                next_tm  = (tm[b] != '0) ? tm[b] - 1'b1 : tm[b];
                next_mtm = (mtm[b] != '0) ? mtm[b] - 1'b1 : mtm[b];
                case (st[b])
                    blc_pkg::BLC_ACTIVATING:
                        if (tm[b] == '0) next_st = blc_pkg::BLC_ACTIVE;
                    blc_pkg::BLC_PRECHARGING, blc_pkg::BLC_RD_AP,
                    blc_pkg::BLC_WR_AP, blc_pkg::BLC_REFRESHING,
                    blc_pkg::BLC_MR_WRITING, blc_pkg::BLC_RESETTING:
                        if (tm[b] == '0) next_st = blc_pkg::BLC_IDLE;
                    blc_pkg::BLC_MR_READING:
                        if (mtm[b] == '0) next_st = ret[b];
                    default:
                        next_st = st[b];
                endcase
                if (mine)
                begin
                    case (CMD.code)
                        blc_pkg::BLC_ACT:
                        begin
                            next_st = blc_pkg::BLC_ACTIVATING;
                            next_tm = `BLC_TW'(`BLC_RCD_CYC);
                        end
                        blc_pkg::BLC_RD, blc_pkg::BLC_WR:
                        begin
                            if (CMD.auto_pre)
                            begin
                                next_st = (CMD.code == blc_pkg::BLC_RD) ?
                                    blc_pkg::BLC_RD_AP : blc_pkg::BLC_WR_AP;
                                next_tm = `BLC_TW'(`BLC_BURST_CYC +
                                                   `BLC_RP_CYC);
                            end
                            else
                            begin
                                next_st = (CMD.code == blc_pkg::BLC_RD) ?
                                    blc_pkg::BLC_READING :
                                    blc_pkg::BLC_WRITING;
                                next_tm = `BLC_TW'(`BLC_BURST_CYC);
                            end
                        end
                        blc_pkg::BLC_PRE:
                        begin
                            next_st = blc_pkg::BLC_PRECHARGING;
                            next_tm = `BLC_TW'(`BLC_RP_CYC);
                        end
                        blc_pkg::BLC_REF_PB, blc_pkg::BLC_REF_AB:
                        begin
                            next_st = blc_pkg::BLC_REFRESHING;
                            next_tm = (CMD.code == blc_pkg::BLC_REF_PB) ?
                                `BLC_TW'(`BLC_RFCPB_CYC) :
                                `BLC_TW'(`BLC_RFCAB_CYC);
                        end
                        blc_pkg::BLC_MRW:
                        begin
                            next_st = CMD.mr_reset ? blc_pkg::BLC_RESETTING
                                : blc_pkg::BLC_MR_WRITING;
                            next_tm = CMD.mr_reset ?
                                `BLC_TW'(`BLC_INIT_CYC) :
                                `BLC_TW'(`BLC_MRW_CYC);
                        end
                        blc_pkg::BLC_MRR:
                        begin
                            next_st  = blc_pkg::BLC_MR_READING;
                            next_ret = st[b];
                            next_mtm = `BLC_TW'(`BLC_MRR_CYC);
                        end
                        default:
                            next_st = st[b];
                    endcase
                end
            end

            always_ff @(posedge CLK)
            begin
                if (RST)
                begin
                    st[b]  <= blc_pkg::BLC_POWER_ON;
                    ret[b] <= blc_pkg::BLC_POWER_ON;
                    tm[b]  <= '0;
                    mtm[b] <= '0;
                end
                else
                begin
                    st[b]  <= next_st;
                    ret[b] <= next_ret;
                    tm[b]  <= next_tm;
                    mtm[b] <= next_mtm;
                end
            end
        end

        // four-activate window slots, one ring entry per activate
        for (b = 0; b < 4; b = b + 1)
        begin : g_faw
            always_ff @(posedge CLK)
            begin
                if (RST)
                    faw[b] <= '0;
                else if (act_acc && faw_ptr == 2'(b))
                    faw[b] <= `BLC_TW'(`BLC_FAW_CYC);
                else if (faw[b] != '0)
                    faw[b] <= faw[b] - 1'b1;
            end
        end

        // masked write bytes
        for (b = 0; b < 4; b = b + 1)
        begin : g_mask
            always_ff @(posedge CLK)
            begin
                if (RST)
                    data[8*b +: 8] <= 8'h00;
                else if (WDATA.valid && !WDATA.write_byte_mask[b])
                    data[8*b +: 8] <= WDATA.data[8*b +: 8];
            end
        end
    endgenerate

    // ==========================================
    // activate gap, power-down exit, self refresh
    wire cke_rise = ~cke_prev & CKE;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            cke_prev <= 1'b0;
            sref     <= 1'b0;
            xt       <= '0;
            rrd      <= '0;
            faw_ptr  <= 2'h0;
        end
        else
        begin
            cke_prev <= CKE;
            if (sre_acc)
                sref <= 1'b1;
            else if (cke_rise)
                sref <= 1'b0;
            if (cke_rise)
                xt <= sref ? `BLC_TW'(`BLC_XSR_CYC)
                           : `BLC_TW'(`BLC_XP_CYC);
            else if (xt != '0)
                xt <= xt - 1'b1;
            if (act_acc)
            begin
                rrd     <= `BLC_TW'(`BLC_RRD_CYC);
                faw_ptr <= faw_ptr + 2'h1;
            end
            else if (rrd != '0)
                rrd <= rrd - 1'b1;
        end
    end

    // ==========================================
    // avalon-mm registers
    wire req     = AVS_READ | AVS_WRITE;
    wire wr_take = AVS_WRITE & ack;
    wire clr_err = wr_take & (AVS_ADDRESS == `BLC_REG_STATUS) &
                   AVS_BYTEENABLE[0] & AVS_WRITEDATA[`BLC_ST_ERR];

    logic [31:0] banks_word;
    logic [31:0] status_word;
    logic [31:0] rd_mux;
    always_comb
    begin
        for (int i = 0; i < `BLC_BANKS; i++)
            banks_word[4*i +: 4] = st[i];
        status_word = 32'h0000_0000;
        status_word[`BLC_ST_ERR]       = err;
        status_word[`BLC_ST_GATED]     = ~cke_held | (xt != '0);
        status_word[`BLC_ST_RESETTING] = |rst_v;
        status_word[`BLC_ST_ALLIDLE]   = all_idle;
        status_word[`BLC_ST_SREF]      = sref;
        status_word[`BLC_ST_CODE_LO +: 4] = err_code;
        case (AVS_ADDRESS)
            `BLC_REG_CTRL:   rd_mux = {31'h0000_0000, chk_en};
            `BLC_REG_STATUS: rd_mux = status_word;
            `BLC_REG_BANKS:  rd_mux = banks_word;
            `BLC_REG_DATA:   rd_mux = data;
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    assign AVS_WAITREQUEST = req & ~ack;
    assign STORED_DATA     = data;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ack          <= 1'b0;
            AVS_READDATA <= 32'h0000_0000;
            chk_en       <= `BLC_CTRL_RST;
            err          <= 1'b0;
            err_code     <= 4'h0;
        end
        else
        begin
            ack <= req & ~ack;
            if (AVS_READ && !ack)
                AVS_READDATA <= rd_mux;
            if (wr_take && AVS_ADDRESS == `BLC_REG_CTRL && AVS_BYTEENABLE[0])
                chk_en <= AVS_WRITEDATA[0];
            if (bad && chk_en)
            begin
                err      <= 1'b1;
                err_code <= CMD.code;
            end
            else if (clr_err)
                err <= 1'b0;
        end
    end

endmodule // blc_bank_command_legality

// ---- tb/blc_legality_properties.sv ----
`timescale 1ns/1ns
module blc_legality_properties (
    // clock and reset
    input wire logic                CLK,
    input wire logic                RST,
    // command side
    input wire logic                CKE,
    input wire blc_pkg::blc_cmd_t   CMD,
    input wire blc_pkg::blc_wdata_t WDATA,
    // outcome
    input wire logic                CMD_ACCEPT,
    input wire logic                CMD_ILLEGAL,
    input wire logic [7:0]          BANK_IDLE,
    input wire logic [31:0]         STORED_DATA
);
    // ==========================================
    // decode
    wire        is_nop  = CMD.code == blc_pkg::BLC_NOP;
    wire        took    = CMD.valid && CMD_ACCEPT;
    wire        any_rsp = CMD_ACCEPT || CMD_ILLEGAL;
    wire [3:0]  m       = WDATA.write_byte_mask;
    wire [31:0] mask32  = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_closed;
        BANK_IDLE == 8'h00;
    endsequence
    sequence s_open;
        BANK_IDLE == 8'hFF;
    endsequence

    // ==========================================
    // properties
    a_nop_silent:
    assert property (CMD.valid && is_nop |-> !any_rsp)
        else $error("no-op drew a response");
    a_idle_kept:
    assert property (!CMD.valid || is_nop |=>
        (BANK_IDLE & $past(BANK_IDLE)) == $past(BANK_IDLE))
        else $error("idle bank left idle without command");
    a_cke_low_quiet:
    assert property (!CKE && CMD.valid && CMD.code != blc_pkg::BLC_SRE
        |-> !any_rsp) else $error("command answered with enable low");
    a_act_opens_bank:
    assert property (took && CMD.code == blc_pkg::BLC_ACT
        |-> BANK_IDLE[CMD.bank] ##1 !BANK_IDLE[$past(CMD.bank)])
        else $error("activate not tied to an idle bank");
    a_preall_closes:
    assert property (took && CMD.code == blc_pkg::BLC_PRE
        && CMD.all_bank_select |=> s_closed [*2] ##[1:8] s_open)
        else $error("precharge-all timing off");
    a_cfg_write_busy:
    assert property (took && CMD.code == blc_pkg::BLC_MRW && !CMD.mr_reset
        |=> s_closed [*8] ##[1:6] s_open)
        else $error("config write time off");
    a_mask_keeps:
    assert property (WDATA.valid |=>
        ((STORED_DATA ^ $past(STORED_DATA)) & $past(mask32)) == 32'h0)
        else $error("masked byte was stored");
    a_mask_stores:
    assert property (took && CMD.code == blc_pkg::BLC_WR && WDATA.valid
        |=> ((STORED_DATA ^ $past(WDATA.data)) & ~$past(mask32)) == 32'h0)
        else $error("unmasked byte not stored");
endmodule // blc_legality_properties

bind blc_bank_command_legality blc_legality_properties u_props (
    .CLK(CLK), .RST(RST), .CKE(CKE), .CMD(CMD), .WDATA(WDATA),
    .CMD_ACCEPT(CMD_ACCEPT), .CMD_ILLEGAL(CMD_ILLEGAL),
    .BANK_IDLE(BANK_IDLE), .STORED_DATA(STORED_DATA));

// ---- tb/blc_ctrl_model.sv ----
`timescale 1ns/1ns
module blc_ctrl_model (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // request from the bench
    input  wire blc_pkg::blc_cmd_t   req,
    input  wire blc_pkg::blc_wdata_t req_wd,
    input  wire logic                req_cke,
    // toward the device
    output blc_pkg::blc_cmd_t        cmd,
    output blc_pkg::blc_wdata_t      wdata,
    output logic                     cke
);
    // ==========================================
    // launch one clock after the request, no-op otherwise
    always_ff @(posedge clk)
    begin
        cke <= !rst && req_cke;
        if (rst)
            cmd <= '0;
        else if (req.valid)
            cmd <= req;
        else
            cmd <= {5'h00, ~cmd[5:0]};
        if (rst)
            wdata <= '0;
        else if (req_wd.valid)
            wdata <= req_wd;
        else
            wdata <= {1'b0, ~wdata[35:0]};
    end
endmodule // blc_ctrl_model

// ---- tb/tb_bank_command_legality.sv ----
`timescale 1ns/1ns
`include "blc_cfg.svh"
`define TB_CHECK(name, want, got) \
    begin \
        tests_run++; \
        if ((got) !== (want)) \
        begin \
            n_mismatch++; \
            $display("[FAIL] %s expected %0h seen %0h", name, want, got); \
        end \
    end

module tb_bank_command_legality;
    // ==========================================
    // signals
    logic                CLK = 1'b0;
    logic                RST = 1'b1;
    blc_pkg::blc_cmd_t   req = '0;
    blc_pkg::blc_wdata_t req_wd = '0;
    blc_pkg::blc_wdata_t wd = '0;
    logic                req_cke = 1'b1;
    blc_pkg::blc_cmd_t   cmd;
    blc_pkg::blc_wdata_t wdata;
    logic                cke;
    logic                acc;
    logic                ill;
    logic [7:0]          bank_idle;
    logic [31:0]         stored;
    logic [4:0]          avs_addr = '0;
    logic                avs_read = 1'b0;
    logic                avs_write = 1'b0;
    logic [31:0]         avs_wdata = '0;
    logic [31:0]         avs_rdata;
    logic                avs_wait;
    logic [31:0]         rd;
    int                  n_mismatch = 0;
    int                  tests_run = 0;

    blc_ctrl_model ctrl (.clk(CLK), .rst(RST), .req(req), .req_wd(req_wd),
        .req_cke(req_cke), .cmd(cmd), .wdata(wdata), .cke(cke));
    blc_bank_command_legality uut (.CLK(CLK), .RST(RST), .CKE(cke),
        .CMD(cmd), .WDATA(wdata), .CMD_ACCEPT(acc), .CMD_ILLEGAL(ill),
        .BANK_IDLE(bank_idle), .STORED_DATA(stored),
        .AVS_ADDRESS(avs_addr), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_wdata), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(avs_rdata), .AVS_WAITREQUEST(avs_wait));

    initial
    begin
        forever #4 CLK = ~CLK;
    end

    // ==========================================
    // shared tasks
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic send(input blc_pkg::blc_code_t c, input logic [2:0] b,
                        input logic [2:0] f, input logic [1:0] want);
        @(posedge CLK);
        req    <= {1'b1, c, b, f};
        req_wd <= wd;
        @(posedge CLK);
        req.valid    <= 1'b0;
        req_wd.valid <= 1'b0;
        wd = '0;
        @(negedge CLK);
        `TB_CHECK("accept and refuse", want, {acc, ill})
    endtask

    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int i;
        i = 0;
        @(posedge CLK);
        avs_addr  <= a;
        avs_write <= w;
        avs_read  <= !w;
        avs_wdata <= d;
        do
        begin
            @(posedge CLK);
            i++;
        end
        while (avs_wait !== 1'b0 && i < 16);
        // read data taken at the edge that sees waitrequest low
        rd = avs_rdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (avs_wait !== 1'b0)
        begin
            $display("[FAIL] waitrequest expected 0 seen %0h", avs_wait);
            n_mismatch++;
            test_done();
        end
    endtask

    // ==========================================
    // scenarios
    task automatic t_power_on;
        @(negedge CLK);
        `TB_CHECK("banks after reset", 8'h00, bank_idle)
        bus(1'b0, `BLC_REG_CTRL, '0);
        `TB_CHECK("ctrl reset", 1'b1, rd[0])
        bus(1'b0, 5'h10, '0);
        `TB_CHECK("unmapped", 32'h0, rd)
        send(blc_pkg::BLC_MRW, 3'h0, 3'b001, 2'b10);
        send(blc_pkg::BLC_MRR, 3'h3, 3'h0, 2'b10);
        repeat (1260) @(negedge CLK);
        `TB_CHECK("init done", 8'hFF, bank_idle)
        bus(1'b0, `BLC_REG_BANKS, '0);
        `TB_CHECK("states", {8{4'(blc_pkg::BLC_IDLE)}}, rd)
        $display("test power_on done");
    endtask

    task automatic t_bank_mix;
        send(blc_pkg::BLC_ACT, 3'h0, 3'h0, 2'b10);
        send(blc_pkg::BLC_MRR, 3'h0, 3'h0, 2'b10);
        repeat (6) @(negedge CLK);
        wd = {1'b1, 32'h11223344, 4'h0};
        send(blc_pkg::BLC_WR, 3'h0, 3'h0, 2'b10);
        send(blc_pkg::BLC_RD, 3'h0, 3'h0, 2'b01);
        bus(1'b0, `BLC_REG_STATUS, '0);
        `TB_CHECK("err code", {4'(blc_pkg::BLC_RD), 1'b1}, {rd[11:8], rd[0]})
        bus(1'b1, `BLC_REG_STATUS, 32'h1);
        wd = {1'b1, 32'hAABBCCDD, 4'h5};
        send(blc_pkg::BLC_WR, 3'h0, 3'h0, 2'b10);
        bus(1'b0, `BLC_REG_DATA, '0);
        `TB_CHECK("stored word", 32'hAA22CC44, rd)
        repeat (4) @(negedge CLK);
        send(blc_pkg::BLC_RD, 3'h0, 3'b010, 2'b10);
        send(blc_pkg::BLC_ACT, 3'h1, 3'h0, 2'b10);
        repeat (12) @(negedge CLK);
        `TB_CHECK("bank mix", 8'hFD, bank_idle)
        $display("test bank_mix done");
    endtask

    task automatic t_close_all;
        send(blc_pkg::BLC_PRE, 3'h5, 3'b100, 2'b10);
        repeat (8) @(negedge CLK);
        `TB_CHECK("all closed", 8'hFF, bank_idle)
        send(blc_pkg::BLC_MRW, 3'h0, 3'h0, 2'b10);
        send(blc_pkg::BLC_ACT, 3'h2, 3'h0, 2'b01);
        send(blc_pkg::BLC_NOP, 3'h2, 3'h0, 2'b00);
        repeat (12) @(negedge CLK);
        `TB_CHECK("config write over", 8'hFF, bank_idle)
        $display("test close_all done");
    endtask

    task automatic t_reinit;
        @(posedge CLK);
        RST <= 1'b1;
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        repeat (2) @(negedge CLK);
        `TB_CHECK("banks after reinit", 8'h00, bank_idle)
        send(blc_pkg::BLC_MRW, 3'h0, 3'b001, 2'b10);
        repeat (1260) @(negedge CLK);
        `TB_CHECK("reinit done", 8'hFF, bank_idle)
        send(blc_pkg::BLC_REF_PB, 3'h6, 3'h0, 2'b10);
        @(negedge CLK);
        `TB_CHECK("bank refreshing", 8'hBF, bank_idle)
        repeat (13) @(negedge CLK);
        `TB_CHECK("refresh over", 8'hFF, bank_idle)
        $display("test reinit done");
    endtask

    task automatic t_cke_gate;
        @(posedge CLK);
        req_cke <= 1'b0;
        req     <= {1'b1, blc_pkg::BLC_SRE, 3'h0, 3'h0};
        @(posedge CLK);
        req.valid <= 1'b0;
        @(negedge CLK);
        `TB_CHECK("self refresh entry", 2'b10, {acc, ill})
        send(blc_pkg::BLC_ACT, 3'h4, 3'h0, 2'b00);
        @(posedge CLK);
        req_cke <= 1'b1;
        send(blc_pkg::BLC_ACT, 3'h4, 3'h0, 2'b01);
        repeat (20) @(negedge CLK);
        send(blc_pkg::BLC_ACT, 3'h4, 3'h0, 2'b10);
        $display("test cke_gate done");
    endtask

    initial
    begin
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        repeat (2) @(posedge CLK);
        t_power_on();
        t_bank_mix();
        t_close_all();
        t_reinit();
        t_cke_gate();
        test_done();
    end
endmodule // tb_bank_command_legality
